/* src/ptr_ops_pkg.sv */
package ptr_ops_pkg;
   localparam int          word_width      = 16;
   localparam int          ptr_width       = 12;
   localparam int          pc_width        = 21;
   localparam int          lit_width       = 6;
   localparam int          sel_width       = 2;
   localparam int          ptr_count       = 3;
   localparam logic [7:0]  opcode_prefix   = 8'he8;
   localparam int          prefix_lsb      = 8;
   localparam int          sel_lsb         = 6;
   localparam logic [1:0]  sel_return      = 2'h3;
   localparam logic [1:0]  third_ptr_index = 2'h2;
   localparam int          phases_per_cycle = 4;
   localparam logic [1:0]  last_phase      = 2'h3;
   localparam logic [1:0]  multiplied_phase = 2'h0;

   typedef enum logic [2:0] {
      st_idle   = 3'b001,
      st_return = 3'b010,
      st_refill = 3'b100
   } seq_state_type;
endpackage

/* src/cycle_phase_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module cycle_phase_gen
   import ptr_ops_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   // configuration
   input  wire logic       multiplier_mode,
   // phase outputs
   output logic [1:0]      phase,
   output logic            cycle_end
);
   logic [1:0] next_phase;

   // with the multiplying loop each core clock is already one cycle
   assign next_phase = multiplier_mode ? multiplied_phase
                     : ((phase == last_phase) ? 2'h0 : phase + 2'h1);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase     <= 2'h0;
         cycle_end <= 1'b0;
      end else begin
         phase     <= next_phase;
         cycle_end <= (next_phase == last_phase) | multiplier_mode;
      end
   end
endmodule
`default_nettype wire

/* src/pointer_add_literal_ops.sv */
`timescale 1ns/1ps
`default_nettype none
module pointer_add_literal_ops
   import ptr_ops_pkg::*;
#(
   parameter int ptr_w = ptr_width,
   parameter int pc_w  = pc_width
)(
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   reset_n,
   // clock configuration, level from the core on the same clock
   input  wire logic                   multiplier_mode,
   // instruction fetch
   input  wire logic                   instr_valid,
   input  wire logic [word_width-1:0]  instr_word,
   // return stack
   input  wire logic [pc_w-1:0]        return_stack_top,
   // pointer preload from the core
   input  wire logic                   ptr_load,
   input  wire logic [sel_width-1:0]   ptr_load_sel,
   input  wire logic [ptr_w-1:0]       ptr_load_value,
   // results
   output logic [ptr_w-1:0]            file_select_pointer [ptr_count],
   output logic [pc_w-1:0]             pc_load_value,
   output logic                        pc_load,
   output logic                        pop_stack,
   output logic                        nop_cycle,
   output logic                        busy,
   output logic                        phase_end,
   output logic                        status_write
);
   seq_state_type               state;
   seq_state_type               next_state;
   logic [1:0]                  phase;
   logic                        cycle_end;
   logic                        is_prefix;
   logic                        is_return;
   logic                        is_add_literal_to_pointer;
   logic                        is_add_literal_pointer_two_and_return;
   logic                        take;
   logic [sel_width-1:0]        target_sel;
   logic [ptr_w-1:0]            literal_ext;

   cycle_phase_gen u_phase (
      .ref_clk         (ref_clk),
      .reset_n         (reset_n),
      .multiplier_mode (multiplier_mode),
      .phase           (phase),
      .cycle_end       (cycle_end)
   );

   // decode happens once per instruction cycle, at the write phase
   assign is_prefix   = (instr_word[word_width-1:prefix_lsb] == opcode_prefix);
   assign is_return   = (instr_word[sel_lsb+sel_width-1:sel_lsb] == sel_return);
   assign take        = cycle_end && instr_valid && is_prefix && (state == st_idle);
   assign is_add_literal_to_pointer             = take && !is_return;
   assign is_add_literal_pointer_two_and_return = take && is_return;
   assign target_sel  = is_return ? third_ptr_index
                                  : instr_word[sel_lsb+sel_width-1:sel_lsb];
   // literal is unsigned, zero-extended
   assign literal_ext = {{(ptr_w-lit_width){1'b0}}, instr_word[lit_width-1:0]};

   always_comb begin
      next_state = state;
      case (state)
         st_idle:   if (is_add_literal_pointer_two_and_return) next_state = st_return;
         st_return: next_state = st_refill;
         st_refill: if (cycle_end) next_state = st_idle;
         default:   next_state = st_idle;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= st_idle;
      end else begin
         state <= next_state;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < ptr_count; gi++) begin : g_ptr
         logic sel_hit;
         assign sel_hit = (target_sel == sel_width'(gi));
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               file_select_pointer[gi] <= '0;
            end else if (take && sel_hit) begin
               // sum wraps at pointer width
               file_select_pointer[gi] <= file_select_pointer[gi] + literal_ext;
            end else if (ptr_load && ptr_load_sel == sel_width'(gi)) begin
               file_select_pointer[gi] <= ptr_load_value;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_load_value <= '0;
         pc_load       <= 1'b0;
         pop_stack     <= 1'b0;
         nop_cycle     <= 1'b0;
         busy          <= 1'b0;
         phase_end     <= 1'b0;
         status_write  <= 1'b0;
      end else begin
         // return follows the pointer write by one clock
         pc_load       <= (state == st_return);
         pop_stack     <= (state == st_return);
         if (state == st_return) begin
            pc_load_value <= return_stack_top;
         end
         nop_cycle     <= (next_state == st_return) || (next_state == st_refill);
         busy          <= (next_state != st_idle);
         phase_end     <= cycle_end;
         status_write  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* bench/ptr_ops_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ptr_ops_chk
   import ptr_ops_pkg::*;
#(parameter int ptr_w = 12, parameter int pc_w = 21)(
   input wire logic                  ref_clk, reset_n, multiplier_mode, instr_valid, ptr_load,
   input wire logic [word_width-1:0] instr_word,
   input wire logic [pc_w-1:0]       return_stack_top, pc_load_value,
   input wire logic [ptr_w-1:0]      file_select_pointer [ptr_count],
   input wire logic                  pc_load, pop_stack, nop_cycle, busy, phase_end, status_write
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence ret_pulse; pc_load && pop_stack ##1 !pc_load; endsequence
   chk_no_flags: assert property (!status_write)
      else $error("status write seen");
   chk_return_pulse: assert property ($rose(busy) |-> ##1 ret_pulse)
      else $error("return pulse missing");
   chk_pc_value: assert property (pc_load |-> pc_load_value == $past(return_stack_top))
      else $error("pc value wrong");
   chk_nop_busy: assert property (nop_cycle == busy)
      else $error("nop and busy differ");
   chk_pc_in_nop: assert property (pc_load |-> nop_cycle && busy && $past(busy))
      else $error("return outside nop cycle");
   chk_busy_span: assert property ($rose(busy) && !multiplier_mode |-> busy[*4] ##1 !busy)
      else $error("busy span wrong");
   chk_third_ptr: assert property ($rose(busy) |-> file_select_pointer[2] ==
      ptr_w'($past(file_select_pointer[2]) + $past(instr_word[5:0]))) else $error("third pointer wrong");
   chk_plain_add: assert property (phase_end && $past(instr_valid && !busy && !ptr_load
      && instr_word[15:6] == {opcode_prefix, 2'h1}) |-> file_select_pointer[1] ==
      ptr_w'($past(file_select_pointer[1]) + $past(instr_word[5:0]))) else $error("plain add wrong");
   chk_cycle_len: assert property (phase_end && !multiplier_mode |=> !phase_end[*3] ##1 phase_end)
      else $error("cycle length wrong");
endmodule
bind pointer_add_literal_ops ptr_ops_chk #(.ptr_w(ptr_w), .pc_w(pc_w)) u_chk (.ref_clk, .reset_n,
   .multiplier_mode, .instr_valid, .ptr_load, .instr_word, .return_stack_top, .pc_load_value,
   .file_select_pointer, .pc_load, .pop_stack, .nop_cycle, .busy, .phase_end, .status_write);
`default_nettype wire

/* bench/pointer_add_literal_ops_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pointer_add_literal_ops_bench;
   import ptr_ops_pkg::*;
`define CHK(n,e,a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
   logic                  ref_clk = 0, reset_n = 0, multiplier_mode = 0, instr_valid = 0, ptr_load = 0;
   logic [word_width-1:0] instr_word = '0;
   logic [1:0]            ptr_load_sel = '0;
   logic [ptr_width-1:0]  ptr_load_value = '0, fsp [ptr_count];
   logic [pc_width-1:0]   return_stack_top = 21'h1abcd, pc_load_value;
   logic                  pc_load, pop_stack, nop_cycle, busy, phase_end, status_write;
   int                    n_mismatch = 0, n_checks = 0;
   pointer_add_literal_ops dut (.ref_clk, .reset_n, .multiplier_mode, .instr_valid, .instr_word,
      .return_stack_top, .ptr_load, .ptr_load_sel, .ptr_load_value, .file_select_pointer(fsp),
      .pc_load_value, .pc_load, .pop_stack, .nop_cycle, .busy, .phase_end, .status_write);
   initial forever #5 ref_clk = ~ref_clk;
   task automatic preload(input logic [1:0] s, input logic [11:0] v);
      @(negedge ref_clk) begin ptr_load = 1; ptr_load_sel = s; ptr_load_value = v; end
      @(negedge ref_clk) ptr_load = 0;
   endtask
   // hold the word until a cycle end has taken it
   task automatic issue(input logic [15:0] w);
      int i;
      @(negedge ref_clk) begin instr_valid = 1; instr_word = w; end
      i = 0;
      do begin @(negedge ref_clk); i++; end while (!phase_end && i < 20);
      instr_valid = 0;
   endtask
   task automatic test_plain;
      for (int s = 0; s < 3; s++) begin
         preload(s[1:0], 12'hffe - s[11:0]);
         issue({opcode_prefix, s[1:0], 6'h3f});
         `CHK("pointer", 12'h03d - s[11:0], fsp[s])
         `CHK("busy", 2'h0, {busy, status_write})
      end
      $display("test_plain done");
   endtask
   task automatic test_return;
      preload(2'h2, 12'h3ff);
      preload(2'h1, 12'h0aa);
      issue({opcode_prefix, 2'h3, 6'h23});
      `CHK("third ptr", 12'h422, fsp[2])
      `CHK("other ptr", 12'h0aa, fsp[1])
      @(negedge ref_clk) begin instr_valid = 1; instr_word = {opcode_prefix, 8'h41}; end
      `CHK("pc strobes", 2'h3, {pc_load, pop_stack})
      `CHK("pc value", 21'h1abcd, pc_load_value)
      repeat (2) @(negedge ref_clk);
      `CHK("nop", 3'h3, {pc_load, nop_cycle, busy})
      @(negedge ref_clk) instr_valid = 0;
      `CHK("busy end", 1'b0, busy)
      `CHK("refused", 12'h0aa, fsp[1])
      $display("test_return done");
   endtask
   task automatic test_mult;
      @(negedge ref_clk) begin reset_n = 0; multiplier_mode = 1; end
      repeat (2) @(negedge ref_clk);
      reset_n = 1;
      preload(2'h0, 12'h100);
      issue({opcode_prefix, 8'h05});
      @(negedge ref_clk);
      `CHK("mult add", 13'h1105, {phase_end, fsp[0]})
      $display("test_mult done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge ref_clk);
      reset_n = 1;
      test_plain;
      test_return;
      test_mult;
      finish_test;
   end
   initial begin
      #100000;
      n_mismatch++;
      finish_test;
   end
endmodule
`default_nettype wire
